// [bench/etd_partner.sv]
// Purpose: word memory and MAC core seen by the engine
// Assumes: bench preloads mem while the engine is idle
// Notes: slow_in stalls memory ack and MAC ready
`timescale 1ns/100ps
`default_nettype none
module etd_partner (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [4:0] flags_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] mem_wdata_in,
    output logic mem_ack_out,
    output logic [31:0] mem_rdata_out,
    input wire logic [7:0] mac_data_in,
    input wire logic mac_sof_in,
    input wire logic mac_eof_in,
    input wire logic mac_valid_in,
    output logic mac_ready_out,
    output logic mac_done_out,
    output logic [4:0] mac_flags_out
);
    // ========================================
    // state
    logic [31:0] mem [0:127];
    logic [9:0] rx [0:31];
    int rx_n = 0;
    logic [2:0] cnt = 3'h0;
    logic [2:0] eof_sr = 3'h0;
    logic ack_q = 1'b0;
    // read data toggles outside an ack so stale words never look valid
    assign mem_ack_out = ack_q;
    assign mem_rdata_out = ack_q ? mem[mem_addr_in[8:2]] : {32{cnt[0]}};
    assign mac_ready_out = !slow_in || cnt[0];
    assign mac_done_out = eof_sr[2];
    assign mac_flags_out = eof_sr[2] ? flags_in : ~flags_in;
    // ========================================
    // behaviour
    always @(posedge clk_in)
    begin
        cnt <= cnt + 3'h1;
        ack_q <= mem_req_in && !ack_q && (!slow_in || cnt[1]);
        if (mem_req_in && ack_q && mem_we_in)
            mem[mem_addr_in[8:2]] <= mem_wdata_in;
        if (mac_valid_in && mac_ready_out)
        begin
            rx[rx_n[4:0]] <= {mac_sof_in, mac_eof_in, mac_data_in};
            rx_n <= rx_n + 1;
        end
        eof_sr <= {eof_sr[1:0], mac_valid_in && mac_ready_out && mac_eof_in};
    end
endmodule
`default_nettype wire

// [bench/etd_tx_dma_bench.sv]
// Purpose: self-checking bench of the transmit descriptor engine
// Assumes: AHB-Lite single word transfers, one slave
// Notes: two ring runs, one stalled with errors, one prompt and clean
`timescale 1ns/100ps
`default_nettype none
module etd_tx_dma_bench;
    // ========================================
    // signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic slow = 1'b1;
    logic [4:0] flags = 5'h05;
    logic hready, req, we, ack, valid, ready, done, sof, eof, irq;
    logic [31:0] hrdata, maddr, mwdata, mrdata, rd;
    logic [7:0] mdata;
    logic [4:0] mflags;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] offs [5] = '{etd_pkg::REG_MODE, etd_pkg::REG_BASE,
        etd_pkg::REG_EVENT, etd_pkg::REG_MASK, 8'h1C};
    logic [9:0] exp_rx [11] = '{10'h211, 10'h022, 10'h033, 10'h044, 10'h055,
        10'h0EE, 10'h0AA, 10'h0BB, 10'h1CC, 10'h211, 10'h122};
    always #25 clk = ~clk;
    etd_tx_dma dut_u (.MCLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(),
        .MEM_REQ_OUT(req), .MEM_WE_OUT(we), .MEM_ADDR_OUT(maddr),
        .MEM_WDATA_OUT(mwdata), .MEM_ACK_IN(ack), .MEM_RDATA_IN(mrdata),
        .MAC_DATA_OUT(mdata), .MAC_SOF_OUT(sof), .MAC_EOF_OUT(eof),
        .MAC_VALID_OUT(valid), .MAC_READY_IN(ready), .MAC_DONE_IN(done),
        .MAC_FLAGS_IN(mflags), .IRQ_OUT(irq));
    etd_partner part_u (.clk_in(clk), .slow_in(slow), .flags_in(flags),
        .mem_req_in(req), .mem_we_in(we), .mem_addr_in(maddr),
        .mem_wdata_in(mwdata), .mem_ack_out(ack), .mem_rdata_out(mrdata),
        .mac_data_in(mdata), .mac_sof_in(sof), .mac_eof_in(eof),
        .mac_valid_in(valid), .mac_ready_out(ready), .mac_done_out(done),
        .mac_flags_out(mflags));
    // ========================================
    // tasks
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic desc(input int i, input logic [31:0] w0, w1, w2);
        part_u.mem[i] = w0;
        part_u.mem[i + 1] = w1;
        part_u.mem[i + 2] = w2;
    endtask
    // polls, since the mask may hide the interrupt
    task automatic wstop;
        rd = 32'h0;
        for (int i = 0; i < 200 && rd[9] !== 1'b1; i++)
            bus(1'b0, etd_pkg::REG_EVENT, 32'h0);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    // ========================================
    // tests
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) rchk(offs[i], 32'h0);
        desc(16, 32'hA000_0000, 32'h5_0000, 32'h100);
        desc(20, 32'h8000_0000, 32'h1_0000, 32'h180);
        desc(24, 32'hD000_0000, 32'h3_0000, 32'h140);
        part_u.mem[64] = 32'h1122_3344;
        part_u.mem[65] = 32'h5566_7788;
        part_u.mem[80] = 32'hAABB_CCDD;
        part_u.mem[96] = 32'hEE00_0000;
        bus(1'b1, etd_pkg::REG_MASK, 32'h200);
        bus(1'b1, etd_pkg::REG_BASE, 32'h40);
        bus(1'b1, etd_pkg::REG_CTRL, 32'h1);
        wstop();
        chk(rd, 32'h305);
        for (int i = 0; i < 9; i++)
            chk(part_u.rx[i], exp_rx[i]);
        chk(part_u.mem[16], 32'h2000_0000);
        chk(part_u.mem[20], 32'h0);
        chk(part_u.mem[24], 32'h5800_0105);
        rchk(etd_pkg::REG_FETCH, 32'h40);
        rchk(etd_pkg::REG_CTRL, 32'h0);
        chk(irq, 32'h1);
        bus(1'b1, etd_pkg::REG_EVENT, 32'h305);
        rchk(etd_pkg::REG_EVENT, 32'h0);
        chk(irq, 32'h0);
        repeat (20) @(posedge clk);
        chk(part_u.rx_n, 32'd9);
        slow <= 1'b0;
        flags <= 5'h00;
        desc(16, 32'hF000_0000, 32'h2_0000, 32'h100);
        bus(1'b1, etd_pkg::REG_MASK, 32'h0);
        bus(1'b1, etd_pkg::REG_CTRL, 32'h1);
        wstop();
        chk(rd, 32'h300);
        chk(irq, 32'h0);
        chk(part_u.rx_n, 32'd11);
        for (int i = 9; i < 11; i++)
            chk(part_u.rx[i], exp_rx[i]);
        chk(part_u.mem[16], 32'h7000_0000);
        rchk(etd_pkg::REG_FETCH, 32'h40);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// [bench/etd_tx_dma_sva.sv]
// Purpose: port checks of the transmit descriptor engine
// Assumes: one clock, synchronous active-low reset
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module etd_tx_dma_sva (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic MEM_REQ_OUT,
    input wire logic MEM_WE_OUT,
    input wire logic [31:0] MEM_ADDR_OUT,
    input wire logic [31:0] MEM_WDATA_OUT,
    input wire logic MEM_ACK_IN,
    input wire logic [7:0] MAC_DATA_OUT,
    input wire logic MAC_VALID_OUT,
    input wire logic MAC_READY_IN,
    input wire logic MAC_DONE_IN
);
    // ========================================
    // sequences
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    sequence s_rd_addr;
        HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
    endsequence
    sequence s_rd_wait;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence
    sequence s_wb;
        MEM_REQ_OUT && MEM_WE_OUT;
    endsequence
    // ========================================
    // properties
    property p_rd_wait;
        s_rd_addr |=> s_rd_wait;
    endproperty
    property p_okay;
        HRESP_OUT == 1'b0;
    endproperty
    property p_mem_hold;
        MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT)
            && $stable(MEM_WE_OUT);
    endproperty
    property p_mem_drop;
        MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT;
    endproperty
    property p_mac_hold;
        MAC_VALID_OUT && !MAC_READY_IN |=> MAC_VALID_OUT
            && $stable(MAC_DATA_OUT);
    endproperty
    property p_wb_owner;
        s_wb |-> !MEM_WDATA_OUT[31] && MEM_ADDR_OUT[3:0] == 4'h0;
    endproperty
    property p_wb_sum;
        s_wb |-> MEM_WDATA_OUT[27] == (|MEM_WDATA_OUT[4:0]);
    endproperty
    property p_wb_abort;
        s_wb |-> MEM_WDATA_OUT[8] == (|MEM_WDATA_OUT[4:0])
            && MEM_WDATA_OUT[26:9] == 18'h0 && MEM_WDATA_OUT[7:5] == 3'h0;
    endproperty
    property p_done_wb;
        MAC_DONE_IN |-> ##[1:40] s_wb;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait missing");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_mem_hold: assert property (p_mem_hold) else $error("req moved");
    a_mem_drop: assert property (p_mem_drop) else $error("req held");
    a_mac_hold: assert property (p_mac_hold) else $error("byte moved");
    a_wb_owner: assert property (p_wb_owner) else $error("owner kept");
    a_wb_sum: assert property (p_wb_sum) else $error("bad error sum");
    a_wb_abort: assert property (p_wb_abort) else $error("bad abort");
    a_done_wb: assert property (p_done_wb) else $error("no write-back");
endmodule
bind etd_tx_dma etd_tx_dma_sva chk_u (.*);
`default_nettype wire

// [common/etd_pkg.sv]
// Purpose: shared constants and types of the transmit descriptor engine
// Assumes: 32-bit word memory, big-endian byte order in buffer words
// Notes: register offsets are byte addresses on the AHB-Lite port
package etd_pkg;

    // ========================================
    // register map
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_BASE = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_EVENT = 8'h0C;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam logic [7:0] REG_FETCH = 8'h14;
    localparam logic [7:0] REG_BUFRD = 8'h18;

    localparam int MODE_DLEN_W = 2;
    localparam logic [MODE_DLEN_W-1:0] MODE_RESET = 2'h0;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic [31:0] DLEN_UNIT = 32'h0000_0010;

    // ========================================
    // event status layout
    localparam int EV_W = 10;
    localparam int EV_FLAGS_LSB = 0;
    localparam int EV_DONE_BIT = 8;
    localparam int EV_STOP_BIT = 9;
    localparam logic [EV_W-1:0] EV_RESET = 10'h000;

    // ========================================
    // descriptor layout
    localparam logic [31:0] W0_OFS = 32'h0000_0000;
    localparam logic [31:0] W1_OFS = 32'h0000_0004;
    localparam logic [31:0] W2_OFS = 32'h0000_0008;
    localparam int W1_LEN_LSB = 16;
    localparam int LEN_W = 16;
    localparam int FLAG_W = 5;

    localparam logic [1:0] POS_MID = 2'h0;
    localparam logic [1:0] POS_END = 2'h1;
    localparam logic [1:0] POS_START = 2'h2;
    localparam logic [1:0] POS_WHOLE = 2'h3;

    typedef struct packed {
        logic tx_desc_owned;
        logic tx_list_last;
        logic tx_frame_pos_hi;
        logic tx_frame_pos_lo;
        logic tx_frame_err_sum;
        logic [17:0] rsvd_hi;
        logic abort;
        logic [2:0] rsvd_mid;
        logic [FLAG_W-1:0] tx_frame_status;
    } etd_td0_t;

    typedef struct packed {
        logic [7:0] data;
        logic sof;
        logic eof;
    } etd_mac_byte_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_W0 = 4'h1,
        ST_RD_W1 = 4'h2,
        ST_RD_W2 = 4'h3,
        ST_RD_BUF = 4'h4,
        ST_PUSH = 4'h5,
        ST_WAIT_MAC = 4'h6,
        ST_WRBACK = 4'h7
    } etd_state_t;

endpackage

// [design/etd_byte_pump.sv]
// Purpose: turns one buffer word into up to four bytes for the MAC
// Assumes: the first byte of a word sits in bits 31:24
// Notes: ready_out is high once the last byte has gone
`timescale 1ns/100ps
`default_nettype none
module etd_byte_pump (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    output logic ready_out,
    input wire logic [31:0] word_in,
    input wire logic [2:0] count_in,
    input wire logic sof_in,
    input wire logic eof_in,
    output etd_pkg::etd_mac_byte_t byte_out,
    output logic valid_out,
    input wire logic ready_in
);

    logic [31:0] word_q;
    logic [2:0] left_q;
    logic eof_q;
    logic sof_q;
    logic eof_now_q;
    logic fire;

    assign fire = valid_out && ready_in;
    assign ready_out = (left_q == 3'h0);
    assign valid_out = (left_q != 3'h0);
    assign byte_out.data = word_q[31:24];
    assign byte_out.sof = sof_q;
    assign byte_out.eof = eof_now_q;

    // eof is kept in a flop per byte so the MAC pin comes from a register
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            word_q <= 32'h0000_0000;
            left_q <= 3'h0;
            eof_q <= 1'b0;
            sof_q <= 1'b0;
            eof_now_q <= 1'b0;
        end
        else if (load_in && ready_out)
        begin
            word_q <= word_in;
            left_q <= count_in;
            eof_q <= eof_in;
            sof_q <= sof_in;
            eof_now_q <= eof_in && (count_in == 3'h1);
        end
        else if (fire)
        begin
            word_q <= {word_q[23:0], 8'h00};
            left_q <= left_q - 3'h1;
            sof_q <= 1'b0;
            eof_now_q <= eof_q && (left_q == 3'h2);
        end
    end

endmodule
`default_nettype wire

// [design/etd_irq_ctrl.sv]
// Purpose: sticky event bits, mask and one level interrupt
// Assumes: clear is write-one-to-clear from the bus
// Notes: a set in the same cycle as its clear keeps the bit set
`timescale 1ns/100ps
`default_nettype none
module etd_irq_ctrl #(
    parameter int W = etd_pkg::EV_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    input wire logic mask_we_in,
    input wire logic [W-1:0] mask_in,
    output logic [W-1:0] status_out,
    output logic [W-1:0] mask_out,
    output logic irq_out
);

    logic [W-1:0] status_d;

    assign status_d = (status_out & ~clr_in) | set_in;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            status_out <= etd_pkg::EV_RESET;
            mask_out <= etd_pkg::EV_RESET;
            irq_out <= 1'b0;
        end
        else
        begin
            status_out <= status_d;
            if (mask_we_in)
            begin
                mask_out <= mask_in;
            end
            irq_out <= |(status_out & mask_out);
        end
    end

endmodule
`default_nettype wire

// [design/etd_tx_dma.sv]
// Purpose: transmit descriptor engine of the ethernet dma engine
// Assumes: one word memory master port, byte stream towards the MAC core
// Notes: registers reached over AHB-Lite, reads take one wait state
// Function
// - walk descriptors and move buffer bytes to the MAC without the CPU
// - word 0 bit 31 is ownership, engine clears it on write-back
// - descriptor not owned stops the engine until software restarts
// - descriptor owned means the engine goes on with it
// - last-in-list bit sends the engine back to the list base
// - word 0 bits 29:28 say middle, end, start or whole frame
// - frame error summary set exactly when a status bit is set
// - status bits 4:0 mirror the MAC event flags
// - abort bit 8 set when any of status bits 4:0 is set
// - word 1 bits 31:16 hold the byte count to transfer
// - start and middle buffers may have any byte count
// - word 1 bits 15:0 are reserved zero
// - word 2 is the full 32-bit buffer start address
`timescale 1ns/100ps
`default_nettype none
module etd_tx_dma (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    output logic MEM_REQ_OUT,
    output logic MEM_WE_OUT,
    output logic [31:0] MEM_ADDR_OUT,
    output logic [31:0] MEM_WDATA_OUT,
    input wire logic MEM_ACK_IN,
    input wire logic [31:0] MEM_RDATA_IN,
    output logic [7:0] MAC_DATA_OUT,
    output logic MAC_SOF_OUT,
    output logic MAC_EOF_OUT,
    output logic MAC_VALID_OUT,
    input wire logic MAC_READY_IN,
    input wire logic MAC_DONE_IN,
    input wire logic [4:0] MAC_FLAGS_IN,
    output logic IRQ_OUT
);

    // ========================================
    // helpers
    function automatic logic [2:0] chunk(input logic [15:0] len);
        chunk = (len >= 16'h0004) ? 3'h4 : len[2:0];
    endfunction

    // ========================================
    // AHB-Lite slave
    logic addr_ok;
    logic wr_q;
    logic [7:0] wa_q;
    logic [7:0] ra_q;
    logic [31:0] rd_mux;
    logic wr_now;
    logic [etd_pkg::MODE_DLEN_W-1:0] mode_q;
    logic [31:0] base_q;
    logic [etd_pkg::EV_W-1:0] ev_status;
    logic [etd_pkg::EV_W-1:0] ev_mask;
    logic [etd_pkg::EV_W-1:0] ev_set;
    logic [etd_pkg::EV_W-1:0] ev_clr;
    logic start_w;
    logic base_we;
    logic mask_we;
    logic run_q;
    logic [31:0] desc_q;
    logic [31:0] baddr_q;

    assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign wr_now = wr_q;
    assign base_we = wr_now && (wa_q == etd_pkg::REG_BASE);
    assign mask_we = wr_now && (wa_q == etd_pkg::REG_MASK);
    assign start_w = wr_now && (wa_q == etd_pkg::REG_CTRL)
        && HWDATA_IN[etd_pkg::CTRL_START_BIT];
    assign ev_clr = (wr_now && (wa_q == etd_pkg::REG_EVENT))
        ? HWDATA_IN[etd_pkg::EV_W-1:0] : '0;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (ra_q)
            etd_pkg::REG_MODE: rd_mux[etd_pkg::MODE_DLEN_W-1:0] = mode_q;
            etd_pkg::REG_BASE: rd_mux = base_q;
            etd_pkg::REG_CTRL: rd_mux[etd_pkg::CTRL_RUN_BIT] = run_q;
            etd_pkg::REG_EVENT: rd_mux[etd_pkg::EV_W-1:0] = ev_status;
            etd_pkg::REG_MASK: rd_mux[etd_pkg::EV_W-1:0] = ev_mask;
            etd_pkg::REG_FETCH: rd_mux = desc_q;
            etd_pkg::REG_BUFRD: rd_mux = baddr_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // reads stall one cycle so a write just before them is already seen
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            ra_q <= 8'h00;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
            HRDATA_OUT <= 32'h0;
        end
        else
        begin
            wr_q <= addr_ok && HWRITE_IN;
            if (addr_ok)
            begin
                wa_q <= HADDR_IN[7:0];
                ra_q <= HADDR_IN[7:0];
            end
            if (addr_ok && !HWRITE_IN)
            begin
                HREADYOUT_OUT <= 1'b0;
            end
            else if (!HREADYOUT_OUT)
            begin
                HRDATA_OUT <= rd_mux;
                HREADYOUT_OUT <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            mode_q <= etd_pkg::MODE_RESET;
            base_q <= etd_pkg::BASE_RESET;
        end
        else if (wr_now && (wa_q == etd_pkg::REG_MODE))
        begin
            mode_q <= HWDATA_IN[etd_pkg::MODE_DLEN_W-1:0];
        end
        else if (base_we)
        begin
            base_q <= HWDATA_IN;
        end
    end

    etd_irq_ctrl #(
        .W(etd_pkg::EV_W)
    ) u_irq (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .mask_we_in(mask_we),
        .mask_in(HWDATA_IN[etd_pkg::EV_W-1:0]),
        .status_out(ev_status),
        .mask_out(ev_mask),
        .irq_out(IRQ_OUT)
    );

    // ========================================
    // descriptor walker
    etd_pkg::etd_state_t state_q;
    etd_pkg::etd_state_t state_d;
    etd_pkg::etd_td0_t w0_q;
    etd_pkg::etd_td0_t wb_word;
    logic [15:0] len_q;
    logic [31:0] word_q;
    logic first_q;
    logic [4:0] flags_q;
    logic acked;
    logic pump_ready;
    logic pump_load;
    logic [2:0] pump_cnt;
    logic pump_eof;
    logic pump_sof;
    logic [31:0] dlen;
    logic [31:0] next_desc;
    logic ends_frame;
    etd_pkg::etd_mac_byte_t mac_byte;

    assign acked = MEM_REQ_OUT && MEM_ACK_IN;
    assign ends_frame = w0_q.tx_frame_pos_lo;
    assign dlen = etd_pkg::DLEN_UNIT << mode_q;
    assign next_desc = w0_q.tx_list_last ? base_q : desc_q + dlen;
    assign pump_load = (state_q == etd_pkg::ST_PUSH) && pump_ready;
    assign pump_cnt = chunk(len_q);
    assign pump_sof = first_q && w0_q.tx_frame_pos_hi;
    assign pump_eof = ends_frame && (len_q <= 16'h0004);

    always_comb
    begin
        wb_word = '0;
        wb_word.tx_list_last = w0_q.tx_list_last;
        wb_word.tx_frame_pos_hi = w0_q.tx_frame_pos_hi;
        wb_word.tx_frame_pos_lo = w0_q.tx_frame_pos_lo;
        wb_word.tx_frame_status = flags_q;
        wb_word.abort = |flags_q;
        wb_word.tx_frame_err_sum = |flags_q;
        wb_word.tx_desc_owned = 1'b0;
    end

    always_comb
    begin
        state_d = state_q;
        ev_set = '0;
        unique case (state_q)
            etd_pkg::ST_IDLE:
                if (start_w)
                begin
                    state_d = etd_pkg::ST_RD_W0;
                end
            etd_pkg::ST_RD_W0:
                if (acked)
                begin
                    if (MEM_RDATA_IN[31])
                    begin
                        state_d = etd_pkg::ST_RD_W1;
                    end
                    else
                    begin
                        state_d = etd_pkg::ST_IDLE;
                        ev_set[etd_pkg::EV_STOP_BIT] = 1'b1;
                    end
                end
            etd_pkg::ST_RD_W1:
                if (acked)
                begin
                    state_d = etd_pkg::ST_RD_W2;
                end
            etd_pkg::ST_RD_W2:
                if (acked)
                begin
                    state_d = etd_pkg::ST_RD_BUF;
                end
            etd_pkg::ST_RD_BUF:
                if (len_q == 16'h0000)
                begin
                    state_d = ends_frame ? etd_pkg::ST_WAIT_MAC
                        : etd_pkg::ST_WRBACK;
                end
                else if (acked)
                begin
                    state_d = etd_pkg::ST_PUSH;
                end
            etd_pkg::ST_PUSH:
                if (pump_ready)
                begin
                    state_d = etd_pkg::ST_RD_BUF;
                end
            etd_pkg::ST_WAIT_MAC:
                if (MAC_DONE_IN)
                begin
                    state_d = etd_pkg::ST_WRBACK;
                    ev_set[etd_pkg::FLAG_W-1:0] = MAC_FLAGS_IN;
                end
            etd_pkg::ST_WRBACK:
                if (acked)
                begin
                    state_d = etd_pkg::ST_RD_W0;
                    ev_set[etd_pkg::EV_DONE_BIT] = ends_frame;
                end
            default: state_d = etd_pkg::ST_IDLE;
        endcase
    end

    // memory request stays up until acknowledged, then drops for at least one cycle
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            MEM_REQ_OUT <= 1'b0;
            MEM_WE_OUT <= 1'b0;
            MEM_ADDR_OUT <= 32'h0;
            MEM_WDATA_OUT <= 32'h0;
        end
        else if (acked)
        begin
            MEM_REQ_OUT <= 1'b0;
            MEM_WE_OUT <= 1'b0;
        end
        else if (!MEM_REQ_OUT)
        begin
            unique case (state_q)
                etd_pkg::ST_RD_W0:
                begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_ADDR_OUT <= desc_q + etd_pkg::W0_OFS;
                end
                etd_pkg::ST_RD_W1:
                begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_ADDR_OUT <= desc_q + etd_pkg::W1_OFS;
                end
                etd_pkg::ST_RD_W2:
                begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_ADDR_OUT <= desc_q + etd_pkg::W2_OFS;
                end
                etd_pkg::ST_RD_BUF:
                begin
                    MEM_REQ_OUT <= (len_q != 16'h0000);
                    MEM_ADDR_OUT <= baddr_q;
                end
                etd_pkg::ST_WRBACK:
                begin
                    MEM_REQ_OUT <= 1'b1;
                    MEM_WE_OUT <= 1'b1;
                    MEM_ADDR_OUT <= desc_q + etd_pkg::W0_OFS;
                    MEM_WDATA_OUT <= wb_word;
                end
                default:
                begin
                    MEM_REQ_OUT <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            state_q <= etd_pkg::ST_IDLE;
            run_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            run_q <= (state_d != etd_pkg::ST_IDLE);
        end
    end

    // a restart refetches the descriptor that stopped the engine
    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            desc_q <= etd_pkg::BASE_RESET;
        end
        else if (base_we && (state_q == etd_pkg::ST_IDLE))
        begin
            desc_q <= HWDATA_IN;
        end
        else if ((state_q == etd_pkg::ST_WRBACK) && acked)
        begin
            desc_q <= next_desc;
        end
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (!RST_N_IN)
        begin
            w0_q <= '0;
            len_q <= 16'h0000;
            baddr_q <= 32'h0;
            word_q <= 32'h0;
            first_q <= 1'b0;
            flags_q <= 5'h00;
        end
        else
        begin
            if (acked && (state_q == etd_pkg::ST_RD_W0))
            begin
                w0_q <= MEM_RDATA_IN;
                flags_q <= 5'h00;
                first_q <= 1'b1;
            end
            if (acked && (state_q == etd_pkg::ST_RD_W1))
            begin
                len_q <= MEM_RDATA_IN[etd_pkg::W1_LEN_LSB +: etd_pkg::LEN_W];
            end
            if (acked && (state_q == etd_pkg::ST_RD_W2))
            begin
                baddr_q <= MEM_RDATA_IN;
            end
            if (acked && (state_q == etd_pkg::ST_RD_BUF))
            begin
                word_q <= MEM_RDATA_IN;
            end
            if (pump_load)
            begin
                len_q <= len_q - {13'h0000, pump_cnt};
                baddr_q <= baddr_q + 32'h0000_0004;
                first_q <= 1'b0;
            end
            if ((state_q == etd_pkg::ST_WAIT_MAC) && MAC_DONE_IN)
            begin
                flags_q <= MAC_FLAGS_IN;
            end
        end
    end

    // ========================================
    // byte stream to the MAC core
    etd_byte_pump u_pump (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .load_in(pump_load),
        .ready_out(pump_ready),
        .word_in(word_q),
        .count_in(pump_cnt),
        .sof_in(pump_sof),
        .eof_in(pump_eof),
        .byte_out(mac_byte),
        .valid_out(MAC_VALID_OUT),
        .ready_in(MAC_READY_IN)
    );

    assign MAC_DATA_OUT = mac_byte.data;
    assign MAC_SOF_OUT = mac_byte.sof;
    assign MAC_EOF_OUT = mac_byte.eof;

endmodule
`default_nettype wire
